/* verilog/pmbf_pkg.sv */
package pmbf_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LQI_TIME_NS   = 64000;
  localparam int LQI_CYC       = (LQI_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CCA_TIME_NS   = 128000;
  localparam int CCA_CYC       = (CCA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // Packet buffers and frame layout
  localparam int         RAM_DEPTH   = 64;
  localparam int         RAM_WIDTH   = 16;
  localparam int         RAM_AW      = 6;
  localparam logic [6:0] MAX_PAYLOAD = 7'h7D;
  localparam logic [6:0] FCS_BYTES   = 7'h02;
  localparam logic [6:0] PRE_BYTES   = 7'h04;
  localparam logic [7:0] PRE_BYTE    = 8'h00;
  localparam logic [7:0] SFD_BYTE    = 8'hA7;
  localparam logic [5:0] LQI_ENTRY   = 6'h3F;
  localparam logic [15:0] CRC_POLY   = 16'h8408;
  localparam logic [15:0] CRC_INIT   = 16'h0000;
  localparam int         FIFO_WIDTH  = 8;
  localparam int         FIFO_DEPTH  = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // States, Gray coded along the frame
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_PRE   = 3'h1,
    TX_SFD   = 3'h3,
    TX_LEN   = 3'h2,
    TX_PAY   = 3'h6,
    TX_FCS   = 3'h7,
    TX_DRAIN = 3'h5
  } pmbf_tx_st_t;

  typedef enum logic [2:0] {
    RX_HUNT = 3'h0,
    RX_SFD  = 3'h1,
    RX_LEN  = 3'h3,
    RX_DATA = 3'h2
  } pmbf_rx_st_t;

  // Reflected CRC-16, one byte, least significant bit first
  function automatic logic [15:0] pmbf_crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : pmbf_crc_byte

endpackage : pmbf_pkg

/* verilog/pmbf_framer.sv */
// Summary of operation
// (R1) Transmit and receive buffers are each 64 entries of 16 bits.
// (R2) Payloads are 1 to 125 bytes; a transmit request with any other length is ignored.
// (R3) A transmit frame starts with four preamble bytes, one SFD byte and one length byte.
// (R4) A CRC-16 over the transmit payload is sent after the last payload byte, low byte first.
// (R5) Receive hunts preamble, SFD and length, then stores payload and FCS in the buffer.
// (R6) The CRC over received payload and FCS is checked and a pass flag is shown.
// (R7) Link quality is the peak energy over 64 us after the SFD, stored in entry 63 high byte; the code takes it at the frame's last byte, even mid-window.
// (R8) The receive interrupt is raised only after the whole frame is stored.
// (R9) The host fills the transmit buffer before it requests a transmission.
// (R10) On request the transmit buffer is read and framed into the physical-layer format.
// (R11) The transmit interrupt is raised only once the last byte has left the device.
// (R12) Clear channel assessment integrates baseband energy over a fixed interval.
// (R13) Byte n of a frame sits in entry n/2, even bytes in bits 7:0, odd bytes in bits 15:8.
`timescale 1ns/1ns

module pmbf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  // Drain side
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // Honest flags from the fill count
  assign o_ready = (cnt_q != FULL);
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem_q[rd_q];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  // Pointer and count next values
  always_comb
  begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push)
      mem_q[wr_q] <= i_data;
  end

  a_fifo_bound: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    cnt_q <= FULL) else $error("fifo count beyond depth");
endmodule : pmbf_fifo

////////////////////////////////////////////////////////////////////////////////

module pmbf_framer (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  // Host transmit buffer and request
  input  wire logic        i_tx_wr_en,
  input  wire logic [5:0]  i_tx_wr_addr,
  input  wire logic [15:0] i_tx_wr_data,
  input  wire logic [6:0]  i_tx_len,
  input  wire logic        i_tx_start,
  output logic             o_tx_busy,
  // Host receive buffer and status
  input  wire logic [5:0]  i_rx_rd_addr,
  output logic [15:0]      o_rx_rd_data,
  output logic [6:0]       o_rx_len,
  output logic             o_crc_ok,
  output logic [7:0]       o_lqi,
  // Interrupt
  input  wire logic        i_irq_clear,
  output logic             o_irq,
  output logic             o_tx_done,
  output logic             o_rx_done,
  // Clear channel assessment
  input  wire logic        i_cca_start,
  input  wire logic [7:0]  i_cca_threshold,
  output logic             o_cca_done,
  output logic             o_cca_busy,
  output logic [7:0]       o_cca_level,
  // Modem side byte streams and energy
  output logic [7:0]       o_tx_byte,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_energy
);
  logic [15:0] tx_ram_q [pmbf_pkg::RAM_DEPTH]; // R1
  logic [15:0] rx_ram_q [pmbf_pkg::RAM_DEPTH]; // R1

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit framer
  pmbf_pkg::pmbf_tx_st_t tx_st_q, tx_st_d;
  logic [6:0]  tcnt_q, tcnt_d, tlen_q, tlen_d;
  logic [15:0] tcrc_q, tcrc_d, tword;
  logic [7:0]  tbyte;
  logic        tpush, fifo_rdy, tx_fin;

  assign tword     = tx_ram_q[tcnt_q[6:1]];
  assign o_tx_busy = (tx_st_q != pmbf_pkg::TX_IDLE);

  // Bytes are pushed only while the fifo has room, so the modem stalls us
  always_comb
  begin
    tx_st_d = tx_st_q;
    tcnt_d  = tcnt_q;
    tlen_d  = tlen_q;
    tcrc_d  = tcrc_q;
    tbyte   = pmbf_pkg::PRE_BYTE;
    tpush   = 1'b0;
    tx_fin  = 1'b0;
    unique case (tx_st_q)
      pmbf_pkg::TX_IDLE:
        if (i_tx_start && i_tx_len != '0 && i_tx_len <= pmbf_pkg::MAX_PAYLOAD) // R2
        begin
          tx_st_d = pmbf_pkg::TX_PRE; // R10
          tcnt_d  = '0;
          tlen_d  = i_tx_len;
          tcrc_d  = pmbf_pkg::CRC_INIT;
        end
      pmbf_pkg::TX_PRE:
      begin
        tpush = fifo_rdy; // R3
        if (tpush)
        begin
          tcnt_d = tcnt_q + 7'h01;
          if (tcnt_q == pmbf_pkg::PRE_BYTES - 7'h01)
            tx_st_d = pmbf_pkg::TX_SFD;
        end
      end
      pmbf_pkg::TX_SFD:
      begin
        tbyte = pmbf_pkg::SFD_BYTE; // R3
        tpush = fifo_rdy;
        if (tpush)
          tx_st_d = pmbf_pkg::TX_LEN;
      end
      pmbf_pkg::TX_LEN:
      begin
        tbyte = {1'b0, tlen_q + pmbf_pkg::FCS_BYTES}; // R3
        tpush = fifo_rdy;
        if (tpush)
        begin
          tx_st_d = pmbf_pkg::TX_PAY;
          tcnt_d  = '0;
        end
      end
      pmbf_pkg::TX_PAY:
      begin
        tbyte = tcnt_q[0] ? tword[15:8] : tword[7:0]; // R13
        tpush = fifo_rdy;
        if (tpush)
        begin
          tcrc_d = pmbf_pkg::pmbf_crc_byte(tcrc_q, tbyte); // R4
          tcnt_d = tcnt_q + 7'h01;
          if (tcnt_q == tlen_q - 7'h01)
          begin
            tx_st_d = pmbf_pkg::TX_FCS;
            tcnt_d  = '0;
          end
        end
      end
      pmbf_pkg::TX_FCS:
      begin
        tbyte = tcnt_q[0] ? tcrc_q[15:8] : tcrc_q[7:0]; // R4
        tpush = fifo_rdy;
        if (tpush)
        begin
          tcnt_d = tcnt_q + 7'h01;
          if (tcnt_q[0])
            tx_st_d = pmbf_pkg::TX_DRAIN;
        end
      end
      pmbf_pkg::TX_DRAIN:
        // Done only when the modem has taken the last byte
        if (!o_tx_valid)
        begin
          tx_st_d = pmbf_pkg::TX_IDLE;
          tx_fin  = 1'b1; // R11
        end
      default:
        tx_st_d = pmbf_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      tx_st_q <= pmbf_pkg::TX_IDLE;
      tcnt_q  <= '0;
      tlen_q  <= '0;
      tcrc_q  <= pmbf_pkg::CRC_INIT;
    end
    else
    begin
      tx_st_q <= tx_st_d;
      tcnt_q  <= tcnt_d;
      tlen_q  <= tlen_d;
      tcrc_q  <= tcrc_d;
    end
    // Host writes are ignored while a frame is going out
    if (i_tx_wr_en && tx_st_q == pmbf_pkg::TX_IDLE) // R9
      tx_ram_q[i_tx_wr_addr] <= i_tx_wr_data;
  end

  pmbf_fifo #(
    .WIDTH (pmbf_pkg::FIFO_WIDTH),
    .DEPTH (pmbf_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_data    (tbyte),
    .i_valid   (tpush),
    .o_ready   (fifo_rdy),
    .o_data    (o_tx_byte),
    .o_valid   (o_tx_valid),
    .i_ready   (i_tx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Receive parser, link quality
  pmbf_pkg::pmbf_rx_st_t rx_st_q, rx_st_d;
  logic [6:0]  rcnt_q, rcnt_d, rlen_q, rlen_d, rxlen_q, rxlen_d;
  logic [15:0] rcrc_q, rcrc_d, rcrc_nx;
  logic [9:0]  lcnt_q, lcnt_d;
  logic [7:0]  lqi_q, lqi_d, lmax_q, lmax_d;
  logic        lrun_q, lrun_d, ok_q, ok_d, rwe, rx_fin;

  assign rcrc_nx = pmbf_pkg::pmbf_crc_byte(rcrc_q, i_rx_byte);

  always_comb
  begin
    rx_st_d = rx_st_q;
    rcnt_d  = rcnt_q;
    rlen_d  = rlen_q;
    rxlen_d = rxlen_q;
    rcrc_d  = rcrc_q;
    ok_d    = ok_q;
    lqi_d   = lqi_q;
    rwe     = 1'b0;
    rx_fin  = 1'b0;
    // Peak energy over the window after the SFD
    lrun_d  = lrun_q && (lcnt_q != 10'(pmbf_pkg::LQI_CYC - 1)); // R7
    lcnt_d  = lrun_q ? lcnt_q + 10'h001 : lcnt_q;
    lmax_d  = (lrun_q && i_energy > lmax_q) ? i_energy : lmax_q;
    if (i_rx_valid)
    begin
      unique case (rx_st_q)
        pmbf_pkg::RX_HUNT:
          if (i_rx_byte != pmbf_pkg::PRE_BYTE)
            rcnt_d = '0;
          else if (rcnt_q == pmbf_pkg::PRE_BYTES - 7'h01)
            rx_st_d = pmbf_pkg::RX_SFD; // R5
          else
            rcnt_d = rcnt_q + 7'h01;
        pmbf_pkg::RX_SFD:
          if (i_rx_byte == pmbf_pkg::SFD_BYTE)
          begin
            rx_st_d = pmbf_pkg::RX_LEN; // R5
            lrun_d  = 1'b1;
            lcnt_d  = '0;
            lmax_d  = '0;
          end
          else if (i_rx_byte != pmbf_pkg::PRE_BYTE)
          begin
            rx_st_d = pmbf_pkg::RX_HUNT;
            rcnt_d  = '0;
          end
        pmbf_pkg::RX_LEN:
        begin
          rcnt_d  = '0;
          rcrc_d  = pmbf_pkg::CRC_INIT;
          rlen_d  = i_rx_byte[6:0];
          // Lengths that cannot hold payload and FCS drop the frame
          if (!i_rx_byte[7] && i_rx_byte[6:0] > pmbf_pkg::FCS_BYTES
              && i_rx_byte[6:0] <= pmbf_pkg::MAX_PAYLOAD + pmbf_pkg::FCS_BYTES) // R2
            rx_st_d = pmbf_pkg::RX_DATA;
          else
            rx_st_d = pmbf_pkg::RX_HUNT;
        end
        pmbf_pkg::RX_DATA:
        begin
          rwe    = 1'b1; // R5
          rcrc_d = rcrc_nx; // R6
          rcnt_d = rcnt_q + 7'h01;
          if (rcnt_q == rlen_q - 7'h01)
          begin
            rx_st_d = pmbf_pkg::RX_HUNT;
            rcnt_d  = '0;
            rx_fin  = 1'b1; // R8
            ok_d    = (rcrc_nx == 16'h0000); // R6
            rxlen_d = rlen_q;
            lqi_d   = lmax_d; // R7
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      rx_st_q <= pmbf_pkg::RX_HUNT;
      rcnt_q  <= '0;
      rlen_q  <= '0;
      rxlen_q <= '0;
      rcrc_q  <= pmbf_pkg::CRC_INIT;
      ok_q    <= 1'b0;
      lqi_q   <= '0;
      lrun_q  <= 1'b0;
      lcnt_q  <= '0;
      lmax_q  <= '0;
    end
    else
    begin
      rx_st_q <= rx_st_d;
      rcnt_q  <= rcnt_d;
      rlen_q  <= rlen_d;
      rxlen_q <= rxlen_d;
      rcrc_q  <= rcrc_d;
      ok_q    <= ok_d;
      lqi_q   <= lqi_d;
      lrun_q  <= lrun_d;
      lcnt_q  <= lcnt_d;
      lmax_q  <= lmax_d;
    end
    // Byte lanes per frame byte parity; frames of 127 bytes leave the high lane free
    if (rwe && rcnt_q[0])
      rx_ram_q[rcnt_q[6:1]][15:8] <= i_rx_byte; // R13
    if (rwe && !rcnt_q[0])
      rx_ram_q[rcnt_q[6:1]][7:0] <= i_rx_byte; // R13
    if (rx_fin)
      rx_ram_q[pmbf_pkg::LQI_ENTRY][15:8] <= lmax_d; // R7
    o_rx_rd_data <= rx_ram_q[i_rx_rd_addr];
  end

  assign o_rx_len = rxlen_q;
  assign o_crc_ok = ok_q;
  assign o_lqi    = lqi_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt flags; a new event beats a clear in the same cycle
  logic txd_q, txd_d, rxd_q, rxd_d;

  always_comb
  begin
    txd_d = tx_fin || (txd_q && !i_irq_clear); // R11
    rxd_d = rx_fin || (rxd_q && !i_irq_clear); // R8
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clear channel assessment: energy sum over a fixed window
  logic [10:0] ccnt_q, ccnt_d;
  logic [18:0] csum_q, csum_d;
  logic [7:0]  clvl_q, clvl_d;
  logic        crun_q, crun_d, cdone_q, cdone_d, cbusy_q, cbusy_d;

  always_comb
  begin
    crun_d  = crun_q;
    ccnt_d  = ccnt_q;
    csum_d  = csum_q;
    clvl_d  = clvl_q;
    cbusy_d = cbusy_q;
    cdone_d = 1'b0;
    if (!crun_q && i_cca_start)
    begin
      crun_d = 1'b1;
      ccnt_d = '0;
      csum_d = '0;
    end
    else if (crun_q)
    begin
      csum_d = csum_q + 19'(i_energy); // R12
      ccnt_d = ccnt_q + 11'h001;
      if (ccnt_q == 11'(pmbf_pkg::CCA_CYC - 1))
      begin
        // Divide by 2048 rather than the 1280-cycle window: cheap, reads 5/8 of the mean
        crun_d  = 1'b0;
        cdone_d = 1'b1;
        clvl_d  = csum_d[18:11];
        cbusy_d = (csum_d[18:11] >= i_cca_threshold); // R12
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      txd_q   <= 1'b0;
      rxd_q   <= 1'b0;
      crun_q  <= 1'b0;
      ccnt_q  <= '0;
      csum_q  <= '0;
      clvl_q  <= '0;
      cdone_q <= 1'b0;
      cbusy_q <= 1'b0;
    end
    else
    begin
      txd_q   <= txd_d;
      rxd_q   <= rxd_d;
      crun_q  <= crun_d;
      ccnt_q  <= ccnt_d;
      csum_q  <= csum_d;
      clvl_q  <= clvl_d;
      cdone_q <= cdone_d;
      cbusy_q <= cbusy_d;
    end
  end

  assign o_tx_done   = txd_q;
  assign o_rx_done   = rxd_q;
  assign o_irq       = txd_q || rxd_q;
  assign o_cca_done  = cdone_q;
  assign o_cca_busy  = cbusy_q;
  assign o_cca_level = clvl_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_pre_last;
    tpush && tx_st_q == pmbf_pkg::TX_PRE && tcnt_q == 7'h03;
  endsequence
  sequence s_fcs_hi;
    tpush && tx_st_q == pmbf_pkg::TX_FCS && tcnt_q[0];
  endsequence

  a_pre_to_sfd: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R3
    s_pre_last |=> tx_st_q == pmbf_pkg::TX_SFD ##0 (tbyte == 8'hA7)) else $error("no SFD");
  a_len_byte: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R3
    tpush && tx_st_q == pmbf_pkg::TX_LEN |-> tbyte == {1'b0, tlen_q + 7'h02}) else $error("len");
  a_fcs_last: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R4
    s_fcs_hi |-> tbyte == tcrc_q[15:8] ##1 tx_st_q == pmbf_pkg::TX_DRAIN) else $error("fcs");
  a_start_len: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R2
    $rose(o_tx_busy) |-> tlen_q != 7'h00 && tlen_q <= 7'h7D) else $error("bad length");
  a_tx_irq_late: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R11
    $rose(txd_q) |-> $past(tx_st_q) == pmbf_pkg::TX_DRAIN && !$past(o_tx_valid))
    else $error("tx irq early");
  a_rx_irq_late: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R8
    $rose(rxd_q) |-> $past(rx_st_q) == pmbf_pkg::RX_DATA && $past(rcnt_q) == $past(rlen_q) - 7'h01)
    else $error("rx irq early");
  a_crc_flag: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R6
    rx_fin |=> ok_q == ($past(rcrc_nx) == 16'h0000)) else $error("crc flag");
  // A fresh SFD on the last window cycle legally restarts the window
  a_lqi_window: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R7
    lrun_q && lcnt_q == 10'h27F && rx_st_d != pmbf_pkg::RX_LEN |=> !lrun_q)
    else $error("lqi window");
  a_cca_done: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R12
    crun_q && ccnt_q == 11'h4FF |=> cdone_q && !crun_q) else $error("cca window");
endmodule : pmbf_framer

/* bench/pmbf_modem_model.sv */
`timescale 1ns/1ns

// Modem stand-in: drains the transmit stream and plays received bytes
module pmbf_modem_model (
  // Clock
  input  wire logic       i_ref_clk,
  // Transmit stream from the framer
  input  wire logic [7:0] i_tx_byte,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  // Receive stream and energy toward the framer
  output logic [7:0]      o_rx_byte,
  output logic            o_rx_valid,
  output logic [7:0]      o_energy
);
  logic [7:0] tx_seen[$];
  bit         stall_en;

  // Quiet lines at time zero
  initial
  begin
    o_rx_byte  = 8'h00;
    o_rx_valid = 1'b0;
    o_energy   = 8'h00;
    stall_en   = 1'b0;
  end

  // Slow modem mode lets the FIFO fill up and refuse
  always @(negedge i_ref_clk)
    o_tx_ready <= stall_en ? ($urandom_range(0, 3) == 0) : 1'b1;

  // Bytes count only on a taken handshake
  always @(posedge i_ref_clk)
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1)
      tx_seen.push_back(i_tx_byte);

  // One received byte per call, back to back across calls
  task automatic send_byte(input logic [7:0] b, input logic [7:0] e);
    @(negedge i_ref_clk);
    o_rx_byte  = b;
    o_rx_valid = 1'b1;
    o_energy   = e;
  endtask : send_byte

  // Idle line shows the inverse, so a stale byte never looks valid
  task automatic go_idle;
    @(negedge i_ref_clk);
    o_rx_byte  = ~o_rx_byte;
    o_rx_valid = 1'b0;
  endtask : go_idle

  task automatic set_energy(input logic [7:0] e);
    o_energy = e;
  endtask : set_energy
endmodule : pmbf_modem_model

/* bench/pmbf_framer_tb.sv */
`timescale 1ns/1ns

module pmbf_framer_tb;
  logic        i_ref_clk, i_reset, i_tx_wr_en, i_tx_start, i_irq_clear, i_cca_start;
  logic        o_tx_busy, o_crc_ok, o_irq, o_tx_done, o_rx_done, o_cca_done, o_cca_busy;
  logic        o_tx_valid, i_tx_ready, i_rx_valid;
  logic [5:0]  i_tx_wr_addr, i_rx_rd_addr;
  logic [15:0] i_tx_wr_data, o_rx_rd_data;
  logic [6:0]  i_tx_len, o_rx_len;
  logic [7:0]  i_cca_threshold, o_lqi, o_cca_level, o_tx_byte, i_rx_byte, i_energy;
  int          bad_count;
  int          tests_run;

  pmbf_framer u_dut (
    .i_ref_clk, .i_reset, .i_tx_wr_en, .i_tx_wr_addr, .i_tx_wr_data, .i_tx_len,
    .i_tx_start, .o_tx_busy, .i_rx_rd_addr, .o_rx_rd_data, .o_rx_len, .o_crc_ok,
    .o_lqi, .i_irq_clear, .o_irq, .o_tx_done, .o_rx_done, .i_cca_start,
    .i_cca_threshold, .o_cca_done, .o_cca_busy, .o_cca_level, .o_tx_byte,
    .o_tx_valid, .i_tx_ready, .i_rx_byte, .i_rx_valid, .i_energy
  );

  pmbf_modem_model u_modem (
    .i_ref_clk, .i_tx_byte(o_tx_byte), .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready),
    .o_rx_byte(i_rx_byte), .o_rx_valid(i_rx_valid), .o_energy(i_energy)
  );

  ////////////////////////////////////////////////////////////
  // 10 MHz reference
  initial
  begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // Reflected CRC-16, worked bit by bit, independent of the design's copy
  function automatic logic [15:0] crc_of(input logic [7:0] d[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (d[i])
      for (int j = 0; j < 8; j++)
        c = (c[0] ^ d[i][j]) ? ((c >> 1) ^ pmbf_pkg::CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc_of

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_flag(input string what, input logic exp, input logic got);
    chk_val(what, {15'h0000, exp}, {15'h0000, got});
  endtask : chk_flag

  task automatic give_verdict;
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic pulse_clear;
    @(negedge i_ref_clk);
    i_irq_clear = 1'b1;
    @(negedge i_ref_clk);
    i_irq_clear = 1'b0;
  endtask : pulse_clear

  // Data shows one cycle after the address edge
  task automatic read_entry(input logic [5:0] a, output logic [15:0] d);
    @(negedge i_ref_clk);
    i_rx_rd_addr = a;
    @(negedge i_ref_clk);
    d = o_rx_rd_data;
  endtask : read_entry

  ////////////////////////////////////////////////////////////
  // Fill buffer, request, then poke it while busy; stream must be unharmed
  task automatic run_tx(input logic [6:0] len, input bit stall);
    logic [7:0]  pay[$];
    logic [7:0]  exp[$];
    logic [15:0] fcs;
    int          n;
    for (int i = 0; i < len; i++)
      pay.push_back(8'($urandom));
    fcs = crc_of(pay);
    exp = '{8'h00, 8'h00, 8'h00, 8'h00, pmbf_pkg::SFD_BYTE, {1'b0, len} + 8'h02};
    exp = {exp, pay, fcs[7:0], fcs[15:8]};
    u_modem.stall_en = stall;
    u_modem.tx_seen.delete();
    for (int i = 0; i < len; i += 2)
    begin
      @(negedge i_ref_clk);
      i_tx_wr_en   = 1'b1;
      i_tx_wr_addr = 6'(i / 2);
      i_tx_wr_data = {(i + 1 < len) ? pay[i + 1] : 8'hEE, pay[i]};
    end
    @(negedge i_ref_clk);
    i_tx_wr_en = 1'b0;
    i_tx_len   = len;
    i_tx_start = 1'b1;
    @(negedge i_ref_clk);
    chk_flag("tx_busy", 1'b1, o_tx_busy);
    i_tx_wr_en   = 1'b1;
    i_tx_wr_addr = 6'h00;
    i_tx_wr_data = ~{pay[0], pay[0]};
    @(negedge i_ref_clk);
    i_tx_wr_en = 1'b0;
    i_tx_start = 1'b0;
    n = 0;
    while (o_tx_done !== 1'b1 && n < 2000)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    chk_val("tx_count", 16'(exp.size()), 16'(u_modem.tx_seen.size()));
    chk_flag("tx_irq", 1'b1, o_irq);
    chk_flag("tx_busy_end", 1'b0, o_tx_busy);
    foreach (exp[i])
      chk_val("tx_byte", {8'h00, exp[i]}, {8'h00, u_modem.tx_seen[i]});
    pulse_clear();
    chk_flag("irq_cleared", 1'b0, o_irq);
  endtask : run_tx

  // Energy spikes before the length byte must stay out of the link quality
  task automatic run_rx(input logic [6:0] len, input bit bad);
    logic [7:0]  fr[$];
    logic [7:0]  e;
    logic [15:0] fcs;
    logic [15:0] w;
    int          n;
    e = 8'($urandom_range(1, 254));
    for (int i = 0; i < len; i++)
      fr.push_back(8'($urandom));
    fcs = crc_of(fr) ^ {15'h0000, bad};
    fr  = {fr, fcs[7:0], fcs[15:8]};
    pulse_clear();
    for (int i = 0; i < 4; i++)
      u_modem.send_byte(8'h00, 8'hFF);
    u_modem.send_byte(pmbf_pkg::SFD_BYTE, 8'hFF);
    u_modem.send_byte(8'(fr.size()), e);
    foreach (fr[i])
    begin
      u_modem.send_byte(fr[i], e);
      if (i == fr.size() - 1)
        chk_flag("rx_done_early", 1'b0, o_rx_done);
    end
    u_modem.go_idle();
    n = 0;
    while (o_rx_done !== 1'b1 && n < 4)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    chk_flag("rx_irq", 1'b1, o_irq);
    chk_flag("crc_ok", !bad, o_crc_ok);
    chk_val("rx_len", 16'(fr.size()), {9'h000, o_rx_len});
    chk_val("lqi", {8'h00, e}, {8'h00, o_lqi});
    foreach (fr[k])
    begin
      read_entry(6'(k / 2), w);
      chk_val("rx_byte", {8'h00, fr[k]}, {8'h00, k[0] ? w[15:8] : w[7:0]});
    end
    read_entry(6'h3F, w);
    chk_val("lqi_entry", {8'h00, e}, {8'h00, w[15:8]});
  endtask : run_rx

  // A second start mid-window must not stretch the measurement
  task automatic run_cca(input logic [7:0] e, input bit above);
    logic [7:0] lvl;
    int         n;
    lvl = 8'((32'(e) * 1280) >> 11);
    u_modem.set_energy(e);
    @(negedge i_ref_clk);
    i_cca_threshold = above ? lvl : lvl + 8'h01;
    i_cca_start     = 1'b1;
    n = 0;
    while (o_cca_done !== 1'b1 && n < 1400)
    begin
      @(negedge i_ref_clk);
      n++;
      i_cca_start = (n == 100);
    end
    chk_val("cca_time", 16'(pmbf_pkg::CCA_CYC + 1), 16'(n));
    chk_val("cca_level", {8'h00, lvl}, {8'h00, o_cca_level});
    chk_flag("cca_busy", above, o_cca_busy);
  endtask : run_cca

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {i_reset, i_tx_wr_en, i_tx_start, i_irq_clear, i_cca_start} = 5'h10;
    {i_tx_wr_addr, i_rx_rd_addr, i_tx_wr_data, i_tx_len, i_cca_threshold} = '0;
    bad_count = 0;
    tests_run = 0;
    void'($urandom(32'h6eeab9bf));
    repeat (5) @(negedge i_ref_clk);
    i_reset = 1'b0;
    chk_flag("irq_reset", 1'b0, o_irq);
    chk_flag("busy_reset", 1'b0, o_tx_busy);
    run_tx(7'h01, 1'b0);
    run_tx(7'h7D, 1'b1);
    run_tx(7'h02, 1'b0);
    repeat (3) run_tx(7'($urandom_range(1, 125)), 1'($urandom));
    // Lengths outside 1 to 125 are refused
    for (int b = 0; b < 2; b++)
    begin
      @(negedge i_ref_clk);
      i_tx_len   = (b != 0) ? 7'h7E : 7'h00;
      i_tx_start = 1'b1;
      @(negedge i_ref_clk);
      i_tx_start = 1'b0;
      chk_flag("busy_refused", 1'b0, o_tx_busy);
    end
    run_rx(7'h01, 1'b0);
    run_rx(7'h7D, 1'b0);
    run_rx(7'($urandom_range(1, 125)), 1'b0);
    run_rx(7'($urandom_range(1, 125)), 1'b1);
    // A frame too short to carry payload and FCS is dropped without notice
    pulse_clear();
    for (int i = 0; i < 4; i++)
      u_modem.send_byte(8'h00, 8'h10);
    u_modem.send_byte(pmbf_pkg::SFD_BYTE, 8'h10);
    repeat (4) u_modem.send_byte(8'h02, 8'h10);
    u_modem.go_idle();
    repeat (4) @(negedge i_ref_clk);
    chk_flag("rx_short_done", 1'b0, o_rx_done);
    run_cca(8'($urandom), 1'b1);
    run_cca(8'($urandom), 1'b0);
    give_verdict();
  end

  // Hang guard, far above the expected run length
  initial
  begin
    #(50000 * 100);
    bad_count++;
    give_verdict();
  end
endmodule : pmbf_framer_tb
